// ===== pkg/wdog_pkg.sv
package wdog_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int unsigned CLK_HZ              = 20_000_000;
	localparam int unsigned WINDOW_TICKS        = 5000;
	localparam int unsigned CLOSED_TICKS        = WINDOW_TICKS / 2;
	localparam int unsigned OPEN_TICKS          = WINDOW_TICKS / 2;
	localparam int unsigned INIT_OPEN_TICKS     = 8 * WINDOW_TICKS;
	localparam int unsigned FAULT_PULSE_TICKS   = 1;
	localparam int unsigned HOLD_TICKS          = 3 * FAULT_PULSE_TICKS;
	localparam int unsigned FLAG_CLEAR_NS       = 5000;
	localparam int unsigned FLAG_CLEAR_CYC      = (FLAG_CLEAR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned DEF_TICK_CYC        = 20;
	localparam int unsigned CNT_W               = 16;
	localparam int unsigned DLY_W               = 8;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic RST_FAULT_PULSE = 1'b1;
	localparam logic RST_FLAG        = 1'b0;
	localparam logic RST_SUPPLY      = 1'b1;

	typedef enum logic [1:0] {
		PH_OFF,
		PH_INIT_OPEN,
		PH_CLOSED,
		PH_OPEN
	} phase_t;

	typedef struct packed {
		logic fault_pulse;
		logic latched_flag;
		logic supply_reset_n;
	} outs_t;

endpackage

// ===== core/window_watchdog.sv
`timescale 1ns/10ps
// How it works
// (RQ1) window 5000 ticks, fault pulse one tick
// (RQ2) regular closed and open halves each
// (RQ3) first open after init: eight windows
// (RQ4) open-phase service restarts closed phase
// (RQ5) service in closed phase is fault
// (RQ6) open phase expiring unserviced is fault
// (RQ7) host holds service three pulse lengths
// (RQ8) watchdog active while enable input low
// (RQ9) rising supply reset initialises when enabled
// (RQ10) enable falling with reset high initialises
// (RQ11) pulsed option: fault rising edge reinitialises
// (RQ12) pulsed option: fault low one tick
// (RQ13) flag option: flag latches, reset pulses low
// (RQ14) pulsed option restarts long initial phase
// (RQ15) flag holds until disable or service
// (RQ16) service clears flag about 5 us later
// (RQ17) no fault keeps outputs idle
// (RQ18) supply reset comes from power-on logic
// (RQ19) supply low clears flag, rise reinitialises
// (RQ20) oscillator modelled as prescaler tick
module window_watchdog
	import wdog_pkg::*;
#(
	parameter int unsigned TICK_CYC = DEF_TICK_CYC,
	parameter bit          FLAG_OPT = 1'b0
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	// host pins
	input  wire logic watchdog_enable_n_i,
	input  wire logic service_strobe_i,
	// power-on reset from supply monitor
	input  wire logic por_reset_n_i,
	// outputs
	output logic      fault_pulse_out_o,
	output logic      latched_flag_out_o,
	output logic      supply_reset_n_o
);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0] en_n_sync;
	logic [1:0] srv_sync;
	logic [1:0] por_sync;
	logic       en_n_d;
	logic       srv_d;
	logic       rst_d;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			en_n_sync <= 2'h3;
			srv_sync  <= 2'h0;
			// supply reset idles high: no false low pulse after reset
			por_sync  <= 2'h3;
		end else begin
			en_n_sync <= {en_n_sync[0], watchdog_enable_n_i};
			srv_sync  <= {srv_sync[0], service_strobe_i};
			por_sync  <= {por_sync[0], por_reset_n_i};
		end
	end

	wire enabled  = ~en_n_sync[1]; // RQ8
	wire srv_rise = srv_sync[1] & ~srv_d;
	wire rst_high = supply_reset_n_o;

	// ----------------------------------------
	// oscillator tick
	// ----------------------------------------
	logic [DLY_W-1:0] pre_cnt;
	wire              tick = (pre_cnt == DLY_W'(TICK_CYC - 1)); // RQ20

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			pre_cnt <= '0;
		else
			pre_cnt <= tick ? '0 : pre_cnt + 1'b1;
	end

	// ----------------------------------------
	// window state
	// ----------------------------------------
	phase_t           phase;
	phase_t           next_phase;
	logic [CNT_W-1:0] win_cnt;
	logic [CNT_W-1:0] next_win_cnt;
	logic             pulse_busy;
	logic             flag_pend;
	logic [DLY_W-1:0] clr_cnt;

	function automatic logic [CNT_W-1:0] phase_len(input phase_t p);
		case (p)
			PH_INIT_OPEN: phase_len = CNT_W'(INIT_OPEN_TICKS); // RQ3
			PH_CLOSED:    phase_len = CNT_W'(CLOSED_TICKS); // RQ2
			PH_OPEN:      phase_len = CNT_W'(OPEN_TICKS); // RQ2
			default:      phase_len = '0;
		endcase
	endfunction

	wire is_open   = (phase == PH_INIT_OPEN) || (phase == PH_OPEN);
	wire expired   = tick && (win_cnt == phase_len(phase) - 1'b1);
	wire flt_close = enabled && (phase == PH_CLOSED) && srv_rise; // RQ5
	wire flt_open  = enabled && is_open && expired && !srv_rise; // RQ6
	wire fault     = flt_close | flt_open;
	wire good_srv  = enabled && is_open && srv_rise; // RQ4
	wire pulse_end = pulse_busy && tick; // RQ1
	wire rst_rise  = rst_high && !rst_d;
	wire en_fall   = !en_n_sync[1] && en_n_d;
	wire init_evt  = (rst_rise && enabled) || (en_fall && rst_high) // RQ9 RQ10
	                 || (!FLAG_OPT && pulse_end && rst_high && enabled); // RQ11 RQ14

	always_comb begin
		next_phase   = phase;
		next_win_cnt = tick ? win_cnt + 1'b1 : win_cnt;
		if (!enabled || !rst_high) begin
			next_phase   = PH_OFF;
			next_win_cnt = '0;
		end else if (init_evt) begin
			next_phase   = PH_INIT_OPEN;
			next_win_cnt = '0;
		end else if (fault) begin
			next_phase   = FLAG_OPT ? PH_INIT_OPEN : PH_OFF;
			next_win_cnt = '0;
		end else if (good_srv) begin
			next_phase   = PH_CLOSED;
			next_win_cnt = '0;
		end else if (expired) begin
			next_phase   = PH_OPEN;
			next_win_cnt = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			phase   <= PH_OFF;
			win_cnt <= '0;
			en_n_d  <= 1'b1;
			srv_d   <= 1'b0;
			rst_d   <= 1'b1;
		end else begin
			phase   <= next_phase;
			win_cnt <= next_win_cnt;
			en_n_d  <= en_n_sync[1];
			srv_d   <= srv_sync[1];
			rst_d   <= rst_high;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// pulse runs to its end even when disabled, as the pin would
	wire pulse_start = fault && !pulse_busy;
	wire flag_clr_go = flag_pend && (clr_cnt == DLY_W'(FLAG_CLEAR_CYC - 1));

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pulse_busy         <= 1'b0;
			fault_pulse_out_o  <= RST_FAULT_PULSE;
			latched_flag_out_o <= RST_FLAG;
			supply_reset_n_o   <= RST_SUPPLY;
			flag_pend          <= 1'b0;
			clr_cnt            <= '0;
		end else begin
			if (pulse_start)
				pulse_busy <= 1'b1;
			else if (pulse_end)
				pulse_busy <= 1'b0;
			fault_pulse_out_o <= !(FLAG_OPT == 1'b0 && (pulse_start || (pulse_busy && !tick))); // RQ12 RQ17
			supply_reset_n_o  <= por_sync[1] && !(FLAG_OPT && (pulse_start || (pulse_busy && !tick))); // RQ13 RQ18
			if (FLAG_OPT && fault)
				latched_flag_out_o <= 1'b1; // RQ13
			else if (!por_sync[1] || (en_n_sync[1] && !en_n_d) || flag_clr_go)
				latched_flag_out_o <= 1'b0; // RQ15 RQ19
			if (good_srv && latched_flag_out_o) begin
				flag_pend <= 1'b1; // RQ16
				clr_cnt   <= '0;
			end else if (flag_clr_go || !latched_flag_out_o) begin
				flag_pend <= 1'b0;
				clr_cnt   <= '0;
			end else if (flag_pend) begin
				clr_cnt <= clr_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_closed_srv;
		phase == PH_CLOSED && enabled && rst_high && !init_evt && srv_rise;
	endsequence

	a_closed_service_faults: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ5
		s_closed_srv |-> fault)
		else $error("closed service not flagged");
	a_open_service_closes: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ4
		good_srv && rst_high && !init_evt |=> phase == PH_CLOSED && win_cnt == '0)
		else $error("open service did not start closed phase");
	a_pulse_one_tick: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ12
		$rose(pulse_busy) |-> ##[1:25] !pulse_busy)
		else $error("fault pulse too long");
	a_pulsed_low: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ12
		!FLAG_OPT && pulse_start |=> !fault_pulse_out_o)
		else $error("fault output not low");
	a_flag_latched: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ13
		FLAG_OPT && fault |=> latched_flag_out_o)
		else $error("flag not latched");
	a_disable_off: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ8
		!enabled |=> phase == PH_OFF)
		else $error("watchdog ran while disabled");
	a_reset_init: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ9
		rst_rise && enabled |=> phase == PH_INIT_OPEN)
		else $error("no init on reset rise");
	a_flag_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ16
		$rose(flag_pend) && !fault |-> ##[1:110] !latched_flag_out_o || fault)
		else $error("flag not cleared after service");

	// ----------------------------------------
	// option, phase and output checks
	// ----------------------------------------
	sequence s_open_miss;
		enabled && rst_high && is_open && expired && !srv_rise;
	endsequence

	sequence s_pulse_begin;
		!FLAG_OPT && pulse_start;
	endsequence

	a_open_miss_faults: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ6
		s_open_miss |=> (FLAG_OPT ? latched_flag_out_o : !fault_pulse_out_o))
		else $error("missed open phase not flagged");

	a_pulse_begins_low: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ12
		s_pulse_begin |=> !fault_pulse_out_o && pulse_busy)
		else $error("fault pulse did not start");

	a_flag_opt_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ12
		FLAG_OPT |-> fault_pulse_out_o)
		else $error("flag option drove fault output");

	a_pulsed_flag_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ13
		!FLAG_OPT |-> !latched_flag_out_o)
		else $error("pulsed option drove flag output");

	a_pulsed_reset_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ18
		!FLAG_OPT |=> supply_reset_n_o == $past(por_sync[1]))
		else $error("reset output does not follow supply");

	a_fault_restarts_long: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ14
		!FLAG_OPT && pulse_end && rst_high && enabled |=> phase == PH_INIT_OPEN)
		else $error("no long open phase after fault");

	a_enable_fall_init: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ10
		en_fall && rst_high |=> phase == PH_INIT_OPEN)
		else $error("no init on enable fall");

	a_flag_reset_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ13
		FLAG_OPT && pulse_start |=> !supply_reset_n_o)
		else $error("flag fault gave no reset pulse");

	a_pulse_end_clears: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ1
		pulse_end |=> !pulse_busy)
		else $error("pulse outlived its tick");

	a_pulse_release_high: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ12
		!FLAG_OPT && pulse_end |=> fault_pulse_out_o)
		else $error("fault output not released");

	a_supply_clears_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ19
		!por_sync[1] && !(FLAG_OPT && fault) |=> !latched_flag_out_o)
		else $error("supply low left flag set");

	a_closed_len_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ2
		phase == PH_CLOSED |-> win_cnt < CNT_W'(CLOSED_TICKS))
		else $error("closed phase too long");

	a_open_len_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ2
		phase == PH_OPEN |-> win_cnt < CNT_W'(OPEN_TICKS))
		else $error("open phase too long");

	a_init_len_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ3
		phase == PH_INIT_OPEN |-> win_cnt < CNT_W'(INIT_OPEN_TICKS))
		else $error("initial open phase too long");

	a_closed_to_open: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ2
		phase == PH_CLOSED && expired && enabled && rst_high && !init_evt && !srv_rise
		|=> phase == PH_OPEN)
		else $error("closed phase did not open");

	a_disable_clears_flag: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ15
		en_n_sync[1] && !en_n_d |=> !latched_flag_out_o)
		else $error("disable left flag set");

	a_flag_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ15
		latched_flag_out_o && por_sync[1] && !(en_n_sync[1] && !en_n_d) && !flag_clr_go
		|=> latched_flag_out_o)
		else $error("flag dropped without cause");

	a_phase_start_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ3 RQ4
		$changed(phase) |-> win_cnt == '0)
		else $error("phase began with stale count");

	a_tick_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ20
		pre_cnt < DLY_W'(TICK_CYC))
		else $error("prescaler out of range");

	a_clear_wait_bound: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ16
		flag_pend |-> clr_cnt < DLY_W'(FLAG_CLEAR_CYC))
		else $error("flag clear wait overran");

	a_service_arms_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RQ16
		good_srv && latched_flag_out_o |=> flag_pend)
		else $error("service did not arm flag clear");

endmodule // window_watchdog

// ===== testbench/host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// host side: enable level and held service strobe
// ----------------------------------------
module host_model
	import wdog_pkg::*;
#(
	parameter int unsigned TICK_CYC = 2
) (
	// clock
	input  wire logic clk_i,
	// commands from the bench
	input  wire logic en_cmd_i,
	input  wire logic svc_cmd_i,
	// pins toward the watchdog
	output logic      watchdog_enable_n_o,
	output logic      service_strobe_o
);
	int unsigned hold = 0;
	initial watchdog_enable_n_o = 1'b1;
	initial service_strobe_o = 1'b0;
	// one tick of slack so a misaligned prescaler still sees the full hold
	always @(negedge clk_i) begin
		watchdog_enable_n_o <= ~en_cmd_i;
		if (svc_cmd_i && hold == 0) begin
			hold <= (HOLD_TICKS + 1) * TICK_CYC;
			service_strobe_o <= 1'b1;
		end else if (hold > 1) begin
			hold <= hold - 1;
		end else begin
			hold <= 0;
			service_strobe_o <= 1'b0;
		end
	end
endmodule // host_model

// ===== testbench/window_watchdog_tb.sv
`timescale 1ns/10ps
module window_watchdog_tb;
	import wdog_pkg::*;
	localparam int unsigned TC = 2;
	localparam int WIN = WINDOW_TICKS * TC;
	logic clk_i, sys_rst_i, por_reset_n_i, en_cmd, svc_cmd, enable_n, strobe, r, ok;
	outs_t p, f;
	int miscompares, checked, n, w;
	// ----------------------------------------
	// parts: pulsed and flag options share the host pins
	// ----------------------------------------
	host_model #(.TICK_CYC(TC)) host_u (.clk_i(clk_i), .en_cmd_i(en_cmd), .svc_cmd_i(svc_cmd),
		.watchdog_enable_n_o(enable_n), .service_strobe_o(strobe));
	window_watchdog #(.TICK_CYC(TC), .FLAG_OPT(1'b0)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.watchdog_enable_n_i(enable_n), .service_strobe_i(strobe), .por_reset_n_i(por_reset_n_i),
		.fault_pulse_out_o(p.fault_pulse), .latched_flag_out_o(p.latched_flag),
		.supply_reset_n_o(p.supply_reset_n));
	window_watchdog #(.TICK_CYC(TC), .FLAG_OPT(1'b1)) dut_flag_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.watchdog_enable_n_i(enable_n), .service_strobe_i(strobe), .por_reset_n_i(por_reset_n_i),
		.fault_pulse_out_o(f.fault_pulse), .latched_flag_out_o(f.latched_flag),
		.supply_reset_n_o(f.supply_reset_n));
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic report_and_stop();
		if (miscompares == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic exp, input logic got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic rng(input string what, input int lo, input int hi, input int got);
		checked++;
		if (got < lo || got > hi) begin
			miscompares++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk_i);
	endtask
	task automatic service();
		svc_cmd <= 1'b1;
		cyc(1);
		svc_cmd <= 1'b0;
		cyc(1);
	endtask
	// outputs except the flag part's latched flag must stay idle for k cycles
	task automatic quiet(input int k);
		ok = 1'b1;
		repeat (k) begin
			cyc(1);
			if (p.fault_pulse !== 1'b1 || f.supply_reset_n !== 1'b1) ok = 1'b0;
			if (f.fault_pulse !== 1'b1 || p.supply_reset_n !== 1'b1 || p.latched_flag !== 1'b0) ok = 1'b0;
		end
		chk("no fault", 1'b1, ok);
	endtask
	// n: cycles to pulse start, w: pulse width, r: flag-side reset pulse seen
	task automatic fault(input int lim);
		n = 0;
		w = 0;
		r = 1'b0;
		while (p.fault_pulse !== 1'b0 && n < lim) begin
			cyc(1);
			n++;
			r |= (f.supply_reset_n === 1'b0);
		end
		if (n >= lim) begin
			miscompares++;
			report_and_stop();
		end
		repeat (8) begin
			if (p.fault_pulse === 1'b0) w++;
			r |= (f.supply_reset_n === 1'b0);
			cyc(1);
		end
		rng("pulse width", 1, TC, w);
		chk("flag reset pulse", 1'b1, r);
		chk("flag set", 1'b1, f.latched_flag);
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		sys_rst_i = 1'b1;
		por_reset_n_i = 1'b1;
		en_cmd = 1'b1;
		svc_cmd = 1'b0;
		miscompares = 0;
		checked = 0;
		cyc(20);
		sys_rst_i <= 1'b0;
		quiet(2000);
		chk("flag idle", 1'b0, f.latched_flag);
		service();
		quiet(100);
		service();
		fault(100);
		cyc(3000);
		service();
		quiet(50);
		chk("flag before clear", 1'b1, f.latched_flag);
		quiet(150);
		chk("flag cleared", 1'b0, f.latched_flag);
		cyc(WIN / 2 - 100);
		service();
		quiet(200);
		fault(WIN);
		rng("missed open", WIN - 220, WIN - 190, n);
		en_cmd <= 1'b0;
		cyc(20);
		chk("flag off", 1'b0, f.latched_flag);
		service();
		quiet(200);
		en_cmd <= 1'b1;
		cyc(1000);
		service();
		quiet(200);
		cyc(WIN / 2 - 400);
		service();
		fault(300);
		por_reset_n_i <= 1'b0;
		cyc(20);
		chk("flag supply low", 1'b0, f.latched_flag);
		chk("pulsed supply low", 1'b0, p.supply_reset_n);
		por_reset_n_i <= 1'b1;
		cyc(1000);
		service();
		quiet(200);
		report_and_stop();
	end
endmodule // window_watchdog_tb
